// >>> hw/host_bus_control_and_self_status.sv
// host bus control and chip self status register bank with isa side effects
`timescale 1ns/10ps
module host_bus_control_and_self_status #(
    parameter int BURST_CYCLES = hbc_pkg::BURST_CYCLES,
    parameter int GAP_CYCLES = hbc_pkg::GAP_CYCLES
) (
    // clock, reset, enable
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic ce_i,
    // register port
    input wire hbc_pkg::reg_req_t reg_req_i,
    output hbc_pkg::reg_rsp_t reg_rsp_o,
    // status sources and prom configuration
    input wire hbc_pkg::prom_status_t status_i,
    input wire logic prom_serial_in_i,
    input wire logic prom_cfg_valid_i,
    input wire logic [15:0] prom_cfg_data_i,
    // isa cycle and memory base
    input wire hbc_pkg::isa_cycle_t isa_i,
    input wire logic [hbc_pkg::SA_HIGH_BITS-1:0] mem_base_i,
    // wide memory select and ready pins
    output logic wide_mem_sel_b_o,
    output logic wide_mem_sel_oe_o,
    output logic io_chrdy_o,
    output logic io_chrdy_oe_o,
    // receive dma
    input wire logic rx_dma_pending_i,
    input wire logic rx_dma_last_i,
    input wire logic ior_b_i,
    input wire logic dma_acknowledge_line_b_i,
    output logic dma_request_line_o,
    output logic rx_dma_pointer_clear_o,
    output logic rx_dma_buffer_64k_o,
    // host access modes
    output logic memory_mode_o,
    output logic prom_busy_o,
    // interrupt gating
    input wire logic irq_event_i,
    output logic irq_o
);
    import hbc_pkg::*;

    bank_state_t st;
    bank_state_t next_st;
    chip_self_status_t sts;
    host_bus_control_t ctl_wr;
    host_bus_control_t ctl_img;
    logic ctl_hit;
    logic sts_hit;
    logic sa_match;
    logic dma_rd;
    logic wr_clear;

    // address decode of the two registers
    assign ctl_hit = reg_req_i.addr == HOST_BUS_CONTROL_OFS;
    assign sts_hit = reg_req_i.addr == CHIP_SELF_STATUS_OFS;
    assign sa_match = isa_i.sa_high == mem_base_i;
    assign dma_rd = ~ior_b_i & ~dma_acknowledge_line_b_i;

    // live self status image; flags are read as they stand at the read edge
    always_comb
    begin
        sts = chip_self_status_t'(ALL_ZERO);
        sts.id = STS_ID;
        sts.low_voltage_supply_flag = status_i.low_voltage;
        // detection must be taken before start-up can count as finished
        sts.init_done_flag = status_i.init_seq_done & st.detect_taken;
        sts.serial_prom_busy = status_i.prom_chip_select;
        sts.prom_detected = st.prom_detected;
        sts.prom_checksum_good = status_i.prom_checksum_good & st.prom_detected;
        sts.ext_latch_decode_present = status_i.ext_latch_detect;
        sts.prom_small_size = status_i.prom_small_size;
    end

    // write image: identifier forced, clear bit never stored
    always_comb
    begin
        ctl_wr = host_bus_control_t'(reg_req_i.wdata);
        // the reset request is taken before the stored copy drops it
        wr_clear = ctl_wr.rx_dma_pointer_clear;
        ctl_wr.id = CTL_ID;
        ctl_wr.rx_dma_pointer_clear = 1'b0;
        ctl_wr.rsv7 = 1'b0;
        ctl_wr.rsv14 = 1'b0;
        ctl_img = st.ctl;
        ctl_img.id = CTL_ID;
    end

    // next state of the bank
    always_comb
    begin
        next_st = st;
        next_st.rx_clear = 1'b0;
        next_st.rsp.rvalid = 1'b0;

        // first enabled edge after release takes the serial input
        if (!st.detect_taken)
        begin
            next_st.detect_taken = 1'b1;
            next_st.prom_detected = prom_serial_in_i;
        end

        // prom-held initial value replaces the reset image
        if (prom_cfg_valid_i && st.prom_detected)
        begin
            next_st.ctl = host_bus_control_t'(prom_cfg_data_i);
            next_st.ctl.id = CTL_ID;
            next_st.ctl.rx_dma_pointer_clear = 1'b0;
            next_st.ctl.rsv7 = 1'b0;
            next_st.ctl.rsv14 = 1'b0;
        end

        // host write; a write to the status offset changes nothing
        if (reg_req_i.wr && ctl_hit)
        begin
            next_st.ctl = ctl_wr;
            // one-cycle pulse aborts dma, flushes buffers, zeroes the pointer
            next_st.rx_clear = wr_clear;
        end
        // sts_hit writes fall through with no effect

        // host read, answered one cycle later; unmapped reads return zero
        if (reg_req_i.rd)
        begin
            next_st.rsp.rvalid = 1'b1;
            if (ctl_hit)
                next_st.rsp.rdata = 16'(ctl_img);
            else if (sts_hit)
                next_st.rsp.rdata = 16'(sts);
            else
                next_st.rsp.rdata = ALL_ZERO;
        end

        // interrupt only while globally enabled
        next_st.irq = irq_event_i & st.ctl.irq_global_enable;

        // wide memory select, driven only in memory mode
        next_st.mem_sel_oe = st.ctl.memory_mode_enable;
        if (st.ctl.address_match_decode)
            next_st.mem_sel_b = ~(st.ctl.memory_mode_enable & ~isa_i.chip_select_in_b
                & sa_match);
        else
            next_st.mem_sel_b = ~(st.ctl.memory_mode_enable & ~isa_i.chip_select_in_b);

        // ready pulled low only on i/o or memory reads, never during dma
        next_st.rdy_oe = ~st.ctl.wait_state_disable & isa_i.wait_request
            & (isa_i.io_read | isa_i.mem_read) & dma_acknowledge_line_b_i;
    end

    // state register; the enable freezes everything
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            st <= '0;
            st.ctl <= host_bus_control_t'(CTL_RESET);
            st.mem_sel_b <= 1'b1;
        end
        else if (ce_i)
        begin
            st <= next_st;
        end
    end

    // request timing lives in its own counter block
    dma_request_pacer #(
        .BURST_CYCLES(BURST_CYCLES),
        .GAP_CYCLES(GAP_CYCLES)
    ) u_pacer (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .ce_i(ce_i),
        .extend_i(st.ctl.dma_request_extend),
        .burst_limit_i(st.ctl.dma_burst_limit),
        .abort_i(st.rx_clear),
        .pending_i(rx_dma_pending_i),
        .last_i(rx_dma_last_i),
        .dma_rd_i(dma_rd),
        .drq_o(dma_request_line_o)
    );

    // outputs
    assign reg_rsp_o = st.rsp;
    assign wide_mem_sel_b_o = st.mem_sel_b;
    assign wide_mem_sel_oe_o = st.mem_sel_oe;
    assign io_chrdy_o = 1'b0; // open drain: only ever pulls low
    assign io_chrdy_oe_o = st.rdy_oe;
    assign rx_dma_pointer_clear_o = st.rx_clear;
    assign rx_dma_buffer_64k_o = st.ctl.rx_dma_buffer_size;
    assign memory_mode_o = st.ctl.memory_mode_enable;
    assign prom_busy_o = status_i.prom_chip_select;
    assign irq_o = st.irq;

    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    sequence ctl_read_s;
        ce_i && reg_req_i.rd && ctl_hit;
    endsequence

    sequence sts_read_s;
        ce_i && reg_req_i.rd && sts_hit;
    endsequence

    sequence wide_sel_s;
        ce_i && st.ctl.memory_mode_enable && !isa_i.chip_select_in_b;
    endsequence

    sequence ctl_write_s;
        ce_i && reg_req_i.wr && ctl_hit;
    endsequence

    // a host write in the same cycle outranks the prom load
    sequence cfg_load_s;
        ce_i && prom_cfg_valid_i && !(reg_req_i.wr && ctl_hit);
    endsequence

    ctl_id_read_a: assert property (ctl_read_s |=> reg_rsp_o.rvalid
        && reg_rsp_o.rdata[5:0] == CTL_ID)
        else $error("bus control identifier wrong");
    sts_id_read_a: assert property (sts_read_s |=> reg_rsp_o.rvalid
        && reg_rsp_o.rdata[5:0] == STS_ID)
        else $error("self status identifier wrong");
    busy_mirror_a: assert property (sts_read_s |=> reg_rsp_o.rdata[8]
        == $past(status_i.prom_chip_select))
        else $error("busy flag does not follow prom select");
    voltage_flag_a: assert property (sts_read_s |=> reg_rsp_o.rdata[6]
        == $past(status_i.low_voltage))
        else $error("supply flag wrong");
    sts_write_ignored_a: assert property (ce_i && reg_req_i.wr && sts_hit && st.detect_taken
        && !prom_cfg_valid_i |=> $stable(st.ctl) && $stable(st.prom_detected))
        else $error("write to self status changed state");
    init_gate_a: assert property (sts_read_s ##0 !status_i.init_seq_done
        |=> !reg_rsp_o.rdata[7])
        else $error("init done reported before start-up finished");
    checksum_gate_a: assert property (sts_read_s ##0 !st.prom_detected
        |=> !reg_rsp_o.rdata[10])
        else $error("checksum good without a detected prom");
    detect_flag_read_a: assert property (sts_read_s
        |=> reg_rsp_o.rdata[9] == $past(st.prom_detected))
        else $error("detected flag read wrong");
    sts_flags_a: assert property (sts_read_s |=> reg_rsp_o.rdata[11] == $past(status_i.ext_latch_detect)
        && reg_rsp_o.rdata[12] == $past(status_i.prom_small_size))
        else $error("latch decode or size flag wrong");
    detect_sample_a: assert property ($rose(st.detect_taken)
        |-> st.prom_detected == $past(prom_serial_in_i))
        else $error("prom detection not sampled from serial input");
    rx_clear_pulse_a: assert property (ctl_write_s ##0 reg_req_i.wdata[6] |=> rx_dma_pointer_clear_o
        ##1 (!rx_dma_pointer_clear_o || !$past(ce_i)
        || $past(ce_i && reg_req_i.wr && ctl_hit && reg_req_i.wdata[6])))
        else $error("receive dma reset pulse wrong");
    rx_clear_none_a: assert property (ctl_write_s ##0 !reg_req_i.wdata[6]
        |=> !rx_dma_pointer_clear_o)
        else $error("receive dma reset pulse without request");
    buf_size_a: assert property (ctl_write_s
        |=> rx_dma_buffer_64k_o == $past(ctl_wr.rx_dma_buffer_size))
        else $error("buffer size output does not follow write");
    mem_mode_write_a: assert property (ctl_write_s
        |=> memory_mode_o == $past(ctl_wr.memory_mode_enable))
        else $error("memory mode output does not follow write");
    cfg_load_a: assert property (cfg_load_s ##0 st.prom_detected |=> 16'(st.ctl)
        == (($past(prom_cfg_data_i) & 16'hbf00) | {10'h000, CTL_ID}))
        else $error("prom initial value not loaded");
    cfg_refused_a: assert property (cfg_load_s ##0 !st.prom_detected |=> $stable(st.ctl))
        else $error("prom value loaded with no prom detected");
    sel_gate_a: assert property (!wide_mem_sel_oe_o |-> wide_mem_sel_b_o)
        else $error("wide select low outside memory mode");
    sel_match_a: assert property (wide_sel_s ##0 st.ctl.address_match_decode
        && !sa_match |=> wide_mem_sel_b_o)
        else $error("wide select low on address mismatch");
    sel_ext_a: assert property (wide_sel_s ##0 !st.ctl.address_match_decode
        |=> !wide_mem_sel_b_o && wide_mem_sel_oe_o)
        else $error("wide select not driven on chip select");
    irq_gate_a: assert property (ce_i && !st.ctl.irq_global_enable |=> !irq_o)
        else $error("interrupt raised while disabled");
    irq_pass_a: assert property (ce_i && st.ctl.irq_global_enable && irq_event_i |=> irq_o)
        else $error("enabled interrupt event not raised");
    ready_pull_a: assert property (ce_i && !st.ctl.wait_state_disable && isa_i.wait_request
        && isa_i.io_read && dma_acknowledge_line_b_i |=> io_chrdy_oe_o)
        else $error("ready not pulled on requested i/o read wait");
    ready_float_a: assert property (ce_i && (st.ctl.wait_state_disable
        || !dma_acknowledge_line_b_i) |=> !io_chrdy_oe_o)
        else $error("ready driven while disabled or in dma");
endmodule

// >>> include/hbc_pkg.sv
// shared constants and types for the host bus control and self status registers
package hbc_pkg;

    // register byte offsets in the device register space
    localparam logic [15:0] HOST_BUS_CONTROL_OFS = 16'h0116;
    localparam logic [15:0] CHIP_SELF_STATUS_OFS = 16'h0136;
    localparam logic [15:0] PROM_COMMAND_OFS = 16'h0040;
    localparam logic [15:0] PROM_DATA_OFS = 16'h0042;

    // fixed identifier patterns and reset image
    localparam logic [5:0] CTL_ID = 6'h17;
    localparam logic [5:0] STS_ID = 6'h16;
    localparam logic [15:0] CTL_RESET = 16'h0017;
    localparam logic [15:0] ALL_ZERO = 16'h0000;

    // dma burst timing
    localparam int CLK_PERIOD_NS = 50;
    localparam int BURST_MAX_NS = 28000;
    localparam int BURST_GAP_NS = 1300;
    localparam int BURST_CYCLES = BURST_MAX_NS / CLK_PERIOD_NS;
    localparam int GAP_CYCLES = (BURST_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SA_HIGH_BITS = 8;

    // bus control layout, bit 15 down to bit 0
    typedef struct packed {
        logic irq_global_enable;
        logic rsv14;
        logic rx_dma_buffer_size;
        logic wait_state_disable;
        logic dma_burst_limit;
        logic memory_mode_enable;
        logic address_match_decode;
        logic dma_request_extend;
        logic rsv7;
        logic rx_dma_pointer_clear;
        logic [5:0] id;
    } host_bus_control_t;

    // self status layout, bit 15 down to bit 0
    typedef struct packed {
        logic [2:0] rsv;
        logic prom_small_size;
        logic ext_latch_decode_present;
        logic prom_checksum_good;
        logic prom_detected;
        logic serial_prom_busy;
        logic init_done_flag;
        logic low_voltage_supply_flag;
        logic [5:0] id;
    } chip_self_status_t;

    // register port request and answer
    typedef struct packed {
        logic [15:0] addr;
        logic rd;
        logic wr;
        logic [15:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic [15:0] rdata;
        logic rvalid;
    } reg_rsp_t;

    // chip-side status sources
    typedef struct packed {
        logic low_voltage;
        logic init_seq_done;
        logic prom_chip_select;
        logic prom_checksum_good;
        logic prom_small_size;
        logic ext_latch_detect;
    } prom_status_t;

    // isa cycle qualifiers
    typedef struct packed {
        logic chip_select_in_b;
        logic [SA_HIGH_BITS-1:0] sa_high;
        logic io_read;
        logic mem_read;
        logic wait_request;
    } isa_cycle_t;

    // complete state of the register bank
    typedef struct packed {
        host_bus_control_t ctl;
        logic detect_taken;
        logic prom_detected;
        logic rx_clear;
        reg_rsp_t rsp;
        logic irq;
        logic mem_sel_b;
        logic mem_sel_oe;
        logic rdy_oe;
    } bank_state_t;

endpackage

// >>> hw/dma_request_pacer.sv
// dma request timing: demand or single transfer, optional burst limit
`timescale 1ns/10ps
module dma_request_pacer #(
    parameter int BURST_CYCLES = 560,
    parameter int GAP_CYCLES = 26
) (
    // clock, reset, enable
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic ce_i,
    // control
    input wire logic extend_i,
    input wire logic burst_limit_i,
    input wire logic abort_i,
    // receive side and host strobe
    input wire logic pending_i,
    input wire logic last_i,
    input wire logic dma_rd_i,
    output logic drq_o
);
    import hbc_pkg::*;

    localparam int BW = $clog2(BURST_CYCLES + 1);
    localparam int GW = $clog2(GAP_CYCLES + 1);

    // refuse counts the counters cannot serve
    if (BURST_CYCLES < 2 || GAP_CYCLES < 1) begin : g_bad
        $error("dma_request_pacer: burst or gap count out of range");
    end

    typedef struct packed {
        logic drq;
        logic rd_q;
        logic [BW-1:0] burst;
        logic [GW-1:0] gap;
    } pacer_state_t;

    pacer_state_t st;
    pacer_state_t next_st;
    logic rd_start;
    logic rd_end;

    // strobe edges; the strobe is synchronous to clk_i
    assign rd_start = dma_rd_i & ~st.rd_q;
    assign rd_end = ~dma_rd_i & st.rd_q;

    // request sequencing
    always_comb
    begin
        next_st = st;
        next_st.rd_q = dma_rd_i;
        if (abort_i)
        begin
            next_st.drq = 1'b0;
            next_st.burst = '0;
            next_st.gap = '0;
        end
        else if (st.gap != '0)
        begin
            next_st.gap = st.gap - GW'(1);
        end
        else if (st.drq)
        begin
            next_st.burst = burst_limit_i ? st.burst + BW'(1) : '0;
            if (burst_limit_i && st.burst == BW'(BURST_CYCLES - 1))
            begin
                // bus is handed back for the gap time
                next_st.drq = 1'b0;
                next_st.burst = '0;
                next_st.gap = GW'(GAP_CYCLES);
            end
            else if (extend_i && rd_start)
                next_st.drq = 1'b0;
            else if (!extend_i && rd_end && last_i)
                next_st.drq = 1'b0;
            else if (!pending_i)
                next_st.drq = 1'b0;
        end
        else if (pending_i && !dma_rd_i)
        begin
            // wait for the strobe to clear so one read is never counted twice
            next_st.drq = 1'b1;
            next_st.burst = '0;
        end
    end

    // state register
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            st <= '0;
        else if (ce_i)
            st <= next_st;
    end

    assign drq_o = st.drq;

    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    burst_bound_a: assert property (st.drq |-> st.burst < BW'(BURST_CYCLES))
        else $error("request held beyond burst limit");
    gap_quiet_a: assert property (st.gap != '0 |-> !drq_o)
        else $error("request raised during bus release gap");
    extend_drop_a: assert property (ce_i && extend_i && st.drq && rd_start && !abort_i
        |=> !drq_o)
        else $error("extended request not dropped on strobe start");
    abort_drop_a: assert property (ce_i && abort_i |=> !drq_o)
        else $error("request survived receive dma reset");
endmodule

// >>> bench/isa_dma_host.sv
// behavioural isa host dma controller that answers the device request line
`timescale 1ns/10ps
module isa_dma_host (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // request and host mode
    input wire logic drq_i,
    input wire logic single_i,
    input wire logic [3:0] delay_i,
    // strobes back to the device
    output logic ior_b_o,
    output logic ack_b_o
);
    logic [3:0] wait_cnt;
    logic [1:0] phase;

    // strobes move on the falling edge so the device never sees them change at its sampling edge
    always @(negedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            ior_b_o <= 1'b1;
            ack_b_o <= 1'b1;
            wait_cnt <= 4'h0;
            phase <= 2'h0;
        end
        else if (ack_b_o)
        begin
            // a slow host lets the request wait delay_i cycles before granting
            ior_b_o <= 1'b1;
            phase <= 2'h0;
            wait_cnt <= drq_i ? wait_cnt + 4'h1 : 4'h0;
            if (drq_i && wait_cnt >= delay_i)
                ack_b_o <= 1'b0;
        end
        else
        begin
            // read strobe low for two cycles, high for one
            phase <= (phase == 2'h2) ? 2'h0 : phase + 2'h1;
            ior_b_o <= (phase == 2'h2);
            // single transfer gives up after each read, demand waits for the request to drop
            if (phase == 2'h2 && (single_i || !drq_i))
            begin
                ack_b_o <= 1'b1;
                wait_cnt <= 4'h0;
            end
        end
    end
endmodule

// >>> bench/host_bus_control_and_self_status_tb_top.sv
// self-checking bench for the host bus control and self status register bank
`timescale 1ns/10ps
module host_bus_control_and_self_status_tb_top;
    import hbc_pkg::*;
    localparam int BURST = 8;
    localparam int GAP = 2;
    logic clk = 1'b0, rst_b = 1'b0, prom_in = 1'b0, cfg_valid = 1'b0, pending = 1'b0;
    logic irq_ev = 1'b0, single = 1'b0, sel_b, sel_oe, rdy_oe, ior_b, ack_b, drq, clr;
    logic buf64, mem_mode, busy, irq;
    logic ce = 1'b1, last = 1'b0;
    logic [3:0] delay = 4'h0;
    logic [7:0] base = 8'h00;
    logic [15:0] cfg_data = 16'h0000;
    logic [31:0] rnd;
    reg_req_t req = '0;
    reg_rsp_t rsp;
    prom_status_t sts = '0;
    isa_cycle_t isa = '0;
    integer seed = 90, fail_count = 0, checks = 0, i, hi, lo, hi_max, lo_min, seen;

    // short burst and gap counts keep the run brief
    host_bus_control_and_self_status #(.BURST_CYCLES(BURST), .GAP_CYCLES(GAP)) DUT (
        .clk_i(clk), .rst_b_i(rst_b), .ce_i(ce), .reg_req_i(req), .reg_rsp_o(rsp),
        .status_i(sts), .prom_serial_in_i(prom_in), .prom_cfg_valid_i(cfg_valid),
        .prom_cfg_data_i(cfg_data), .isa_i(isa), .mem_base_i(base),
        .wide_mem_sel_b_o(sel_b), .wide_mem_sel_oe_o(sel_oe), .io_chrdy_o(),
        .io_chrdy_oe_o(rdy_oe), .rx_dma_pending_i(pending), .rx_dma_last_i(last),
        .ior_b_i(ior_b), .dma_acknowledge_line_b_i(ack_b), .dma_request_line_o(drq),
        .rx_dma_pointer_clear_o(clr), .rx_dma_buffer_64k_o(buf64),
        .memory_mode_o(mem_mode), .prom_busy_o(busy), .irq_event_i(irq_ev), .irq_o(irq));

    isa_dma_host host (.clk_i(clk), .rst_b_i(rst_b), .drq_i(drq), .single_i(single),
        .delay_i(delay), .ior_b_o(ior_b), .ack_b_o(ack_b));

    // clock generator
    initial
    begin
        forever #25 clk = ~clk;
    end

    // expected status image: detected gates the checksum flag
    function automatic logic [15:0] sts_exp(input prom_status_t s, input logic det);
        return {3'h0, s.prom_small_size, s.ext_latch_detect, s.prom_checksum_good & det,
            det, s.prom_chip_select, s.init_seq_done, s.low_voltage, STS_ID};
    endfunction

    // expected control image: reserved and self-clearing bits read 0
    function automatic logic [15:0] ctl_exp(input logic [15:0] w);
        return (w & 16'hbf00) | {10'h000, CTL_ID};
    endfunction

    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // the prom command and data words are never addressed, so busy is always honoured
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(negedge clk);
        req.addr = a;
        req.wdata = d;
        req.wr = 1'b1;
        @(negedge clk);
        req.wr = 1'b0;
    endtask

    // read is answered at the read edge and checked at the next falling edge
    task automatic rdc(input logic [15:0] a, input logic [15:0] exp);
        @(negedge clk);
        req.addr = a;
        req.rd = 1'b1;
        @(negedge clk);
        req.rd = 1'b0;
        chk({15'h0000, rsp.rvalid}, 16'h0001);
        chk(rsp.rdata, exp);
    endtask

    // bounded wait for the host read strobe to reach a level
    task automatic wait_ior(input logic lvl);
        int n;
        n = 0;
        do
        begin
            @(negedge clk);
            n++;
        end
        while (ior_b !== lvl && n < 40);
        if (ior_b !== lvl)
        begin
            fail_count++;
            finish_test();
        end
    endtask

    initial
    begin
        isa.chip_select_in_b = 1'b1;
        repeat (8) @(negedge clk);
        rst_b = 1'b1;
        rdc(HOST_BUS_CONTROL_OFS, CTL_RESET);
        rdc(CHIP_SELF_STATUS_OFS, sts_exp(sts, 1'b0));
        // a write under a low enable is not taken, and with no prom the load is refused
        ce = 1'b0;
        wr(HOST_BUS_CONTROL_OFS, 16'hffff);
        ce = 1'b1;
        chk({15'h0000, clr}, 16'h0000);
        cfg_data = 16'ha500;
        cfg_valid = 1'b1;
        @(negedge clk);
        cfg_valid = 1'b0;
        rdc(HOST_BUS_CONTROL_OFS, CTL_RESET);
        // random status sources are reported live
        for (i = 0; i < 24; i++)
        begin
            rnd = $random(seed);
            sts = rnd[5:0];
            rdc(CHIP_SELF_STATUS_OFS, sts_exp(sts, 1'b0));
            chk({15'h0000, busy}, {15'h0000, sts.prom_chip_select});
        end
        wr(CHIP_SELF_STATUS_OFS, 16'hffff);
        rdc(CHIP_SELF_STATUS_OFS, sts_exp(sts, 1'b0));
        rdc(16'h0120, ALL_ZERO);
        // random control words, including the self-clearing dma reset
        for (i = 0; i < 16; i++)
        begin
            rnd = $random(seed);
            wr(HOST_BUS_CONTROL_OFS, rnd[15:0]);
            chk({15'h0000, clr}, {15'h0000, rnd[6]});
            rdc(HOST_BUS_CONTROL_OFS, ctl_exp(rnd[15:0]));
            chk({14'h0000, buf64, mem_mode}, {14'h0000, rnd[13], rnd[10]});
        end
        // enable and event in every combination
        for (i = 0; i < 4; i++)
        begin
            wr(HOST_BUS_CONTROL_OFS, {i[0], 15'h0000});
            irq_ev = !i[1];
            @(negedge clk);
            chk({15'h0000, irq}, {15'h0000, i[0] && !i[1]});
        end
        irq_ev = 1'b0;
        // memory mode, decode mode, chip select and address match in every combination
        base = rnd[23:16];
        for (i = 0; i < 16; i++)
        begin
            wr(HOST_BUS_CONTROL_OFS, {5'h00, i[0], i[1], 9'h000});
            isa.chip_select_in_b = !i[2];
            isa.sa_high = i[3] ? base : ~base;
            repeat (2) @(negedge clk);
            chk({15'h0000, sel_oe}, {15'h0000, i[0]});
            if (i[0])
                chk({15'h0000, sel_b}, {15'h0000, !(i[2] && (!i[1] || i[3]))});
        end
        isa.chip_select_in_b = 1'b1;
        isa.wait_request = 1'b1;
        for (i = 0; i < 8; i++)
        begin
            wr(HOST_BUS_CONTROL_OFS, {3'h0, i[0], 12'h000});
            isa.io_read = i[1];
            isa.mem_read = i[2];
            repeat (2) @(negedge clk);
            chk({15'h0000, rdy_oe}, {15'h0000, !i[0] && (i[1] || i[2])});
        end
        isa.io_read = 1'b0;
        isa.mem_read = 1'b0;
        // single transfer with a host of varying speed: each read start takes the request away
        single = 1'b1;
        wr(HOST_BUS_CONTROL_OFS, 16'h0100);
        pending = 1'b1;
        for (i = 0; i < 4; i++)
        begin
            delay = i[3:0];
            wait_ior(1'b0);
            chk({15'h0000, drq}, 16'h0000);
            wait_ior(1'b1);
        end
        // demand mode runs on unless the burst limit cuts it into slices with gaps or the last read of a frame ends it
        single = 1'b0;
        delay = 4'h0;
        // third pass: the last read of a frame ends the demand request
        for (i = 0; i < 3; i++)
        begin
            wr(HOST_BUS_CONTROL_OFS, {4'h0, i[0], 11'h000});
            last = i[1];
            hi = 0;
            lo = 0;
            hi_max = 0;
            lo_min = 99;
            seen = 0;
            repeat (60)
            begin
                @(negedge clk);
                if (drq === 1'b1)
                begin
                    if (seen && lo > 0 && lo < lo_min)
                        lo_min = lo;
                    hi++;
                    lo = 0;
                    seen = 1;
                    if (hi > hi_max)
                        hi_max = hi;
                end
                else
                begin
                    lo++;
                    hi = 0;
                end
            end
            chk({15'h0000, (i == 1) ? (hi_max <= BURST && lo_min >= GAP && lo_min < 99)
                : ((i == 0) ? (hi_max > BURST) : (lo_min < 99))}, 16'h0001);
        end
        last = 1'b0;
        // dma reset in mid-transfer drops the request
        wr(HOST_BUS_CONTROL_OFS, 16'h0040);
        chk({15'h0000, clr}, 16'h0001);
        @(negedge clk);
        chk({15'h0000, drq}, 16'h0000);
        pending = 1'b0;
        // second reset with the serial prom input high
        rst_b = 1'b0;
        prom_in = 1'b1;
        repeat (2) @(negedge clk);
        rst_b = 1'b1;
        rdc(CHIP_SELF_STATUS_OFS, sts_exp(sts, 1'b1));
        cfg_data = 16'ha500;
        cfg_valid = 1'b1;
        @(negedge clk);
        cfg_valid = 1'b0;
        rdc(HOST_BUS_CONTROL_OFS, ctl_exp(cfg_data));
        finish_test();
    end
endmodule
